/* File: dv/dar_regs_assertions.sv */
// Purpose: Port checks of the descriptor attribute bank
// Assumes: One clock, async active-low reset
// Notes:   Bound to dar_regs below
`timescale 1ns/1ps

module dar_regs_assertions
(
   input wire        I_CLK,
   input wire        I_RST_N,
   input wire [7:0]  I_ARADDR,
   input wire        I_ARVALID,
   input wire        O_ARREADY,
   input wire        O_RVALID,
   input wire [1:0]  O_RRESP,
   input wire [31:0] O_RDATA,
   input wire        I_EEPROM_PRESENT,
   input wire        I_OTP_CONFIGURED,
   input wire        O_ATTR_ACTIVE,
   input wire        I_EE_CMD_ISSUE,
   input wire [2:0]  I_EE_CMD,
   input wire        O_EE_WR_VALID,
   input wire        I_IMG_LOAD,
   input wire [55:0] I_IMG_DATA,
   input wire [7:0]  O_OBJ_STORE_LEN,
   input wire [7:0]  O_SS_DEV_LEN,
   input wire [7:0]  O_SS_CFG_LEN,
   input wire [7:0]  O_HS_POLL
);
   // *****
   // Checks
   // *****
   default clocking dcb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);

   sequence ee_write_s;
      I_EE_CMD_ISSUE && I_EE_CMD == 3'h3;
   endsequence

   sequence gap_read_s;
      I_ARVALID && O_ARREADY && I_ARADDR == 8'h48;
   endsequence

   ss_dev_norm_a: assert property (
      O_SS_DEV_LEN == 8'h00 || O_SS_DEV_LEN == 8'h12)
      else $error("superspeed device length not 0 or 18");
   ss_cfg_norm_a: assert property (
      O_SS_CFG_LEN == 8'h00 || O_SS_CFG_LEN == 8'h12)
      else $error("superspeed config length not 0 or 18");
   eeprom_off_a: assert property (
      I_EEPROM_PRESENT [*6] |-> !O_ATTR_ACTIVE)
      else $error("attributes active with eeprom");
   otp_off_a: assert property (
      I_OTP_CONFIGURED [*6] |-> !O_ATTR_ACTIVE)
      else $error("attributes active with otp");
   ee_write_a: assert property (ee_write_s |=> O_EE_WR_VALID)
      else $error("eeprom write byte not sent");
   ee_quiet_a: assert property (
      !(I_EE_CMD_ISSUE && I_EE_CMD == 3'h3) |=> !O_EE_WR_VALID)
      else $error("eeprom write without command");
   img_obj_a: assert property (I_IMG_LOAD |-> ##2
      O_OBJ_STORE_LEN == $past(I_IMG_DATA[55:48], 2))
      else $error("object store length not loaded");
   img_poll_a: assert property (I_IMG_LOAD |-> ##2
      O_HS_POLL == $past(I_IMG_DATA[23:16], 2))
      else $error("highspeed poll not loaded");
   rsvd_top_a: assert property (
      O_RVALID |-> O_RDATA[31:24] == 8'h00)
      else $error("reserved bits read nonzero");
   gap_read_a: assert property (gap_read_s |=>
      O_RVALID && O_RRESP == 2'h2 && O_RDATA == 32'h0)
      else $error("unmapped read not refused");
endmodule

bind dar_regs dar_regs_assertions u_dar_regs_assertions
(
   .I_CLK, .I_RST_N, .I_ARADDR, .I_ARVALID, .O_ARREADY,
   .O_RVALID, .O_RRESP, .O_RDATA, .I_EEPROM_PRESENT,
   .I_OTP_CONFIGURED, .O_ATTR_ACTIVE, .I_EE_CMD_ISSUE,
   .I_EE_CMD, .O_EE_WR_VALID, .I_IMG_LOAD, .I_IMG_DATA,
   .O_OBJ_STORE_LEN, .O_SS_DEV_LEN, .O_SS_CFG_LEN, .O_HS_POLL
);

/* File: dv/dar_regs_test.sv */
// Purpose: Self-checking bench of the descriptor attribute bank
// Assumes: 25 MHz clock, AXI4-Lite master tasks
// Notes:   Write strobes on all lanes unless a scenario narrows them
`timescale 1ns/1ps

`define CHK(act, exp) \
   begin \
      n_checks = n_checks + 1; \
      if ((act) !== (exp)) \
      begin \
         bad_count = bad_count + 1; \
         $display("[ERR] %0t got %h want %h", $time, act, exp); \
      end \
   end

module dar_regs_test;
   reg         clk = 1'h0;
   reg         rst_n = 1'h0;
   reg  [7:0]  aw_addr = 8'h00, ar_addr = 8'h00, rd_byte = 8'h00;
   reg  [31:0] w_data = 32'h0;
   reg  [3:0]  w_strb = 4'hF;
   reg         aw_valid = 1'h0, w_valid = 1'h0, b_ready = 1'h0;
   reg         ar_valid = 1'h0, r_ready = 1'h0, ee_on = 1'h0;
   reg         otp_on = 1'h0, usb_rst = 1'h0, img_ld = 1'h0;
   reg         rd_done = 1'h0, cmd_go = 1'h0;
   reg  [2:0]  cmd = 3'h0;
   reg  [55:0] img = 56'h0;
   wire        awready, wready, bvalid, arready, rvalid, wr_vld, active;
   wire [1:0]  bresp, rresp;
   wire [31:0] rdata;
   wire [7:0]  wr_byte, obj, ss_p, ss_d, ss_c, hs_p, hs_d, hs_c;
   integer     bad_count = 0;
   integer     n_checks = 0;
   integer     i;

   always #20 clk = ~clk;

   dar_regs u_dar_regs
   (
      .I_CLK(clk), .I_RST_N(rst_n), .I_AWADDR(aw_addr),
      .I_AWVALID(aw_valid), .O_AWREADY(awready), .I_WDATA(w_data),
      .I_WSTRB(w_strb), .I_WVALID(w_valid), .O_WREADY(wready),
      .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(b_ready),
      .I_ARADDR(ar_addr), .I_ARVALID(ar_valid), .O_ARREADY(arready),
      .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid),
      .I_RREADY(r_ready), .I_EEPROM_PRESENT(ee_on),
      .I_OTP_CONFIGURED(otp_on), .I_USB_RESET(usb_rst),
      .I_IMG_LOAD(img_ld), .I_IMG_DATA(img), .I_EE_RD_DONE(rd_done),
      .I_EE_RD_BYTE(rd_byte), .I_EE_CMD_ISSUE(cmd_go), .I_EE_CMD(cmd),
      .O_EE_WR_BYTE(wr_byte), .O_EE_WR_VALID(wr_vld),
      .O_ATTR_ACTIVE(active), .O_OBJ_STORE_LEN(obj), .O_SS_POLL(ss_p),
      .O_SS_DEV_LEN(ss_d), .O_SS_CFG_LEN(ss_c), .O_HS_POLL(hs_p),
      .O_HS_DEV_LEN(hs_d), .O_HS_CFG_LEN(hs_c)
   );

   // *****
   // Bus tasks
   // *****
   task wr(input [7:0] a, input [31:0] d, input [1:0] er);
      begin
         aw_addr <= a;
         w_data <= d;
         aw_valid <= 1'h1;
         w_valid <= 1'h1;
         b_ready <= 1'h1;
         do
         begin
            @(posedge clk);
            if (awready) aw_valid <= 1'h0;
            if (wready) w_valid <= 1'h0;
         end while (!bvalid);
         b_ready <= 1'h0;
         `CHK({bvalid, bresp}, {1'h1, er})
         @(posedge clk);
      end
   endtask

   task rd(input [7:0] a, input [31:0] ed, input [1:0] er);
      begin
         ar_addr <= a;
         ar_valid <= 1'h1;
         r_ready <= 1'h1;
         do
         begin
            @(posedge clk);
            if (arready) ar_valid <= 1'h0;
         end while (!rvalid);
         r_ready <= 1'h0;
         `CHK({rvalid, rresp, rdata}, {1'h1, er, ed})
         @(posedge clk);
      end
   endtask

   task pulse_usb;
      begin
         usb_rst <= 1'h1;
         @(posedge clk);
         usb_rst <= 1'h0;
         @(posedge clk);
      end
   endtask

   // *****
   // Scenarios
   // *****
   task t_defaults;
      begin
         `CHK({obj, ss_p, ss_d, ss_c}, 32'h00060000);
         `CHK({hs_p, hs_d, hs_c}, 24'h040000);
         rd(8'h44, 32'h0, 2'h0);
         rd(8'h50, 32'h0, 2'h0);
         rd(8'h54, 32'h00060000, 2'h0);
         rd(8'h58, 32'h00040000, 2'h0);
         rd(8'h48, 32'h0, 2'h2);
         $display("defaults test done");
      end
   endtask

   task t_fields;
      begin
         wr(8'h54, 32'hFF0A0503, 2'h0);
         w_strb <= 4'h4;
         wr(8'h54, 32'h000B7777, 2'h0);
         w_strb <= 4'hF;
         wr(8'h58, 32'hAB081200, 2'h0);
         wr(8'h44, 32'hFFFFFF5A, 2'h0);
         wr(8'h4C, 32'h12345678, 2'h2);
         rd(8'h54, 32'h000B0503, 2'h0);
         rd(8'h58, 32'h00081200, 2'h0);
         rd(8'h44, 32'h0000005A, 2'h0);
         `CHK({ss_p, ss_d, ss_c}, 24'h0B1212);
         `CHK({hs_p, hs_d, hs_c}, 24'h081200);
         pulse_usb;
         rd(8'h54, 32'h00060000, 2'h0);
         rd(8'h58, 32'h00040000, 2'h0);
         $display("fields test done");
      end
   endtask

   task t_image;
      begin
         img <= 56'h30091200051212;
         img_ld <= 1'h1;
         @(posedge clk);
         img_ld <= 1'h0;
         repeat (2) @(posedge clk);
         `CHK({obj, ss_p, ss_d, ss_c}, 32'h30091200);
         `CHK({hs_p, hs_d, hs_c}, 24'h051212);
         wr(8'h50, 32'h11, 2'h0);
         pulse_usb;
         rd(8'h50, 32'h30, 2'h0);
         wr(8'h70, 32'h4, 2'h0);
         wr(8'h50, 32'h22, 2'h0);
         pulse_usb;
         rd(8'h50, 32'h22, 2'h0);
         wr(8'h70, 32'h6, 2'h0);
         rd(8'h50, 32'h30, 2'h0);
         wr(8'h70, 32'h0, 2'h0);
         $display("image test done");
      end
   endtask

   task t_eeprom;
      begin
         rd_byte <= 8'hA5;
         rd_done <= 1'h1;
         @(posedge clk);
         rd_done <= 1'h0;
         rd(8'h44, 32'hA5, 2'h0);
         for (i = 0; i < 2; i = i + 1)
         begin
            cmd <= (i == 0) ? 3'h3 : 3'h0;
            cmd_go <= 1'h1;
            @(posedge clk);
            cmd_go <= 1'h0;
            @(posedge clk);
            `CHK({wr_vld, wr_byte}, {i == 0, 8'hA5});
         end
         $display("eeprom test done");
      end
   endtask

   task t_active;
      begin
         for (i = 0; i < 8; i = i + 1)
         begin
            ee_on <= i[2];
            otp_on <= i[1];
            wr(8'h70, {31'h0, i[0]}, 2'h0);
            repeat (8) @(posedge clk);
            `CHK(active, i == 1);
            rd(8'h70, {31'h0, i[0]}, 2'h0);
            rd(8'h74, {29'h0, 1'h1, i[1], i[2]}, 2'h0);
         end
         ee_on <= 1'h0;
         otp_on <= 1'h0;
         $display("active test done");
      end
   endtask

   task complete_run;
      begin
         $display("checks %0d mismatches %0d", n_checks, bad_count);
         if (bad_count == 0 && n_checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask

   initial
   begin
      repeat (6) @(posedge clk);
      rst_n <= 1'h1;
      repeat (2) @(posedge clk);
      t_defaults;
      t_fields;
      t_image;
      t_eeprom;
      t_active;
      complete_run;
   end

   initial
   begin
      repeat (20000) @(posedge clk);
      bad_count = bad_count + 1;
      complete_run;
   end
endmodule

/* File: hw/dar_len_norm.v */
// Purpose: Normalise a SuperSpeed length field
// Assumes: Combinational, same clock domain
// Notes:   Any nonzero length is presented as a full descriptor
`timescale 1ns/1ps
`include "dar_map.vh"

module dar_len_norm
(
   input  wire [7:0] i_len,
   output wire [7:0] o_len
);

   // ***********************************************************
   // Nonzero means full length
   // ***********************************************************
   assign o_len = (i_len != `DAR_ZERO8) ? `DAR_DESC_LEN_FULL
                                         : `DAR_ZERO8; // R11

endmodule

/* File: hw/dar_map.vh */
// Purpose: Register map and constants of the descriptor attribute bank
// Assumes: AXI4-Lite, 32-bit data, byte addresses
// Notes:   Included by every design file of the bank except dar_sync
`ifndef DAR_MAP_VH
`define DAR_MAP_VH

// ***********************************************************
// Offsets
// ***********************************************************
`define DAR_AW              8
`define DAR_OFF_EE_DATA     8'h44
`define DAR_OFF_OBJ_STORE   8'h50
`define DAR_OFF_SS_LEN      8'h54
`define DAR_OFF_HS_LEN      8'h58
`define DAR_OFF_CTRL        8'h70
`define DAR_OFF_STATUS      8'h74

// ***********************************************************
// Fields
// ***********************************************************
`define DAR_BYTE_MSB        7
`define DAR_POLL_MSB        23
`define DAR_POLL_LSB        16
`define DAR_DEV_MSB         15
`define DAR_DEV_LSB         8
`define DAR_CFG_MSB         7
`define DAR_CFG_LSB         0
`define DAR_CTRL_EMU_BIT    0
`define DAR_CTRL_LITE_BIT   1
`define DAR_CTRL_PROT_BIT   2

// ***********************************************************
// Defaults and values
// ***********************************************************
`define DAR_ZERO8           8'h00
`define DAR_SS_POLL_DEF     8'h06
`define DAR_HS_POLL_DEF     8'h04
`define DAR_DESC_LEN_FULL   8'h12
`define DAR_IMG_W           56
`define DAR_RESP_OKAY       2'h0
`define DAR_RESP_SLVERR     2'h2
`define DAR_CMD_READ        3'h0
`define DAR_CMD_WRITE       3'h3

`endif

/* File: hw/dar_regs.v */
// Purpose: Descriptor attribute and EEPROM data register bank
// Assumes: AXI4-Lite slave, 25 MHz I_CLK, async active-low I_RST_N
// Notes:   Image inputs come from the loader; strap inputs are pins
//
// Behaviour
// R1: EEPROM data keeps one byte in bits 7:0; bits 31:8 read zero.
// R2: Software writes zero length for any block absent from RAM.
// R3: Attributes drive descriptors only with no EEPROM, no OTP, emulation on.
// R4: Software must not write attributes when EEPROM or OTP is present.
// R5: All attribute registers obey reset protection control.
// R6: Nonzero object store length means RAM holds a BOS block.
// R7: Object store length defaults EEPROM, else OTP, else zero.
// R8: USB or lite reset restores last loaded image or fixed default.
// R9: SuperSpeed register: poll 23:16, device 15:8, config 7:0.
// R10: SuperSpeed config block is configuration then interface descriptor.
// R11: Nonzero SuperSpeed length fields are treated as eighteen bytes.
// R12: SuperSpeed poll defaults EEPROM, else OTP, else six.
// R13: SuperSpeed lengths default EEPROM, else OTP, else zero.
// R14: High-Speed register: poll 23:16, device 15:8, config 7:0.
// R15: Software writes only zero or eighteen to High-Speed lengths.
// R16: High-Speed poll defaults EEPROM, else OTP, else four.
// R17: High-Speed lengths default EEPROM, else OTP, else zero.
// R18: Read completion loads EEPROM byte; write sends data byte.
// R19: Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
`include "dar_map.vh"

module dar_regs
(
   input  wire        I_CLK,
   input  wire        I_RST_N,
   input  wire [7:0]  I_AWADDR,
   input  wire        I_AWVALID,
   output reg         O_AWREADY,
   input  wire [31:0] I_WDATA,
   input  wire [3:0]  I_WSTRB,
   input  wire        I_WVALID,
   output reg         O_WREADY,
   output reg  [1:0]  O_BRESP,
   output reg         O_BVALID,
   input  wire        I_BREADY,
   input  wire [7:0]  I_ARADDR,
   input  wire        I_ARVALID,
   output reg         O_ARREADY,
   output reg  [31:0] O_RDATA,
   output reg  [1:0]  O_RRESP,
   output reg         O_RVALID,
   input  wire        I_RREADY,
   input  wire        I_EEPROM_PRESENT,
   input  wire        I_OTP_CONFIGURED,
   input  wire        I_USB_RESET,
   input  wire        I_IMG_LOAD,
   input  wire [55:0] I_IMG_DATA,
   input  wire        I_EE_RD_DONE,
   input  wire [7:0]  I_EE_RD_BYTE,
   input  wire        I_EE_CMD_ISSUE,
   input  wire [2:0]  I_EE_CMD,
   output reg  [7:0]  O_EE_WR_BYTE,
   output reg         O_EE_WR_VALID,
   output reg         O_ATTR_ACTIVE,
   output reg  [7:0]  O_OBJ_STORE_LEN,
   output reg  [7:0]  O_SS_POLL,
   output reg  [7:0]  O_SS_DEV_LEN,
   output reg  [7:0]  O_SS_CFG_LEN,
   output reg  [7:0]  O_HS_POLL,
   output reg  [7:0]  O_HS_DEV_LEN,
   output reg  [7:0]  O_HS_CFG_LEN
);

   // ***********************************************************
   // Declarations
   // ***********************************************************
   wire        ee_present;
   wire        otp_cfg;
   wire [7:0]  ss_dev_n;
   wire [7:0]  ss_cfg_n;
   reg  [7:0]  ee_data_q;
   reg  [7:0]  obj_len_q;
   reg  [23:0] ss_q;
   reg  [23:0] hs_q;
   reg  [55:0] img_q;
   reg         img_valid_q;
   reg         emu_en_q;
   reg         lite_rst_q;
   reg         prot_en_q;
   reg         aw_hold_q;
   reg         w_hold_q;
   reg  [7:0]  awaddr_q;
   reg  [31:0] wdata_q;
   reg  [3:0]  wstrb_q;
   reg  [55:0] restore_d;
   reg  [31:0] rdata_d;
   reg         rd_hit_d;
   wire        wr_go;
   wire        restore;

   // ***********************************************************
   // Synchronised straps and subunits
   // ***********************************************************
   dar_sync u_sync_ee
   (
      .i_clk   (I_CLK),
      .i_rst_n (I_RST_N),
      .i_d     (I_EEPROM_PRESENT),
      .o_q     (ee_present)
   );

   dar_sync u_sync_otp
   (
      .i_clk   (I_CLK),
      .i_rst_n (I_RST_N),
      .i_d     (I_OTP_CONFIGURED),
      .o_q     (otp_cfg)
   );

   dar_len_norm u_norm_dev
   (
      .i_len (ss_q[`DAR_DEV_MSB:`DAR_DEV_LSB]),
      .o_len (ss_dev_n)
   );

   dar_len_norm u_norm_cfg
   (
      .i_len (ss_q[`DAR_CFG_MSB:`DAR_CFG_LSB]),
      .o_len (ss_cfg_n)
   );

   // ***********************************************************
   // Functions
   // ***********************************************************
   function [7:0] merge_byte;
      input [7:0] old_v;
      input [7:0] new_v;
      input       en;
      begin
         merge_byte = en ? new_v : old_v;
      end
   endfunction

   function is_attr;
      input [7:0] a;
      begin
         is_attr = (a == `DAR_OFF_OBJ_STORE) || (a == `DAR_OFF_SS_LEN) ||
                   (a == `DAR_OFF_HS_LEN);
      end
   endfunction

   // ***********************************************************
   // Restore image: loaded image or fixed defaults
   // ***********************************************************
   always @*
   begin
      if (img_valid_q)
         restore_d = img_q; // R8
      else
         restore_d = {`DAR_ZERO8,
                      `DAR_SS_POLL_DEF, `DAR_ZERO8, `DAR_ZERO8,
                      `DAR_HS_POLL_DEF, `DAR_ZERO8,
                      `DAR_ZERO8}; // R12 R16
   end

   // Usb reset protection masks only the USB-reset restore
   assign restore = lite_rst_q | (I_USB_RESET & ~prot_en_q); // R5 R8

   // ***********************************************************
   // Write channel capture
   // ***********************************************************
   assign wr_go = aw_hold_q & w_hold_q & ~O_BVALID;

   always @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         awaddr_q  <= 8'h00;
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
         O_AWREADY <= 1'b0;
         O_WREADY  <= 1'b0;
         O_BVALID  <= 1'b0;
         O_BRESP   <= `DAR_RESP_OKAY;
      end
      else
      begin
         O_AWREADY <= ~aw_hold_q & ~O_AWREADY & I_AWVALID;
         O_WREADY  <= ~w_hold_q & ~O_WREADY & I_WVALID;
         if (O_AWREADY & I_AWVALID)
         begin
            aw_hold_q <= 1'b1;
            awaddr_q  <= I_AWADDR;
         end
         if (O_WREADY & I_WVALID)
         begin
            w_hold_q <= 1'b1;
            wdata_q  <= I_WDATA;
            wstrb_q  <= I_WSTRB;
         end
         if (wr_go)
         begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            O_BVALID  <= 1'b1;
            O_BRESP   <= (is_attr(awaddr_q) ||
                          awaddr_q == `DAR_OFF_EE_DATA ||
                          awaddr_q == `DAR_OFF_CTRL) ?
                         `DAR_RESP_OKAY : `DAR_RESP_SLVERR;
         end
         else if (O_BVALID & I_BREADY)
            O_BVALID <= 1'b0;
      end
   end

   // ***********************************************************
   // Register storage
   // ***********************************************************
   always @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         ee_data_q   <= `DAR_ZERO8;
         obj_len_q   <= `DAR_ZERO8; // R7
         ss_q        <= {`DAR_SS_POLL_DEF, `DAR_ZERO8, `DAR_ZERO8}; // R13
         hs_q        <= {`DAR_HS_POLL_DEF, `DAR_ZERO8, `DAR_ZERO8}; // R17
         img_q       <= {`DAR_IMG_W{1'b0}};
         img_valid_q <= 1'b0;
         emu_en_q    <= 1'b0;
         lite_rst_q  <= 1'b0;
         prot_en_q   <= 1'b0;
      end
      else
      begin
         lite_rst_q <= 1'b0;
         if (I_IMG_LOAD)
         begin
            img_q       <= I_IMG_DATA;
            img_valid_q <= 1'b1;
         end
         if (I_EE_RD_DONE)
            ee_data_q <= I_EE_RD_BYTE; // R18
         if (I_IMG_LOAD)
         begin
            obj_len_q <= I_IMG_DATA[55:48]; // R7
            ss_q      <= I_IMG_DATA[47:24]; // R12 R13
            hs_q      <= I_IMG_DATA[23:0]; // R16 R17
         end
         else if (restore)
         begin
            obj_len_q <= restore_d[55:48]; // R8
            ss_q      <= restore_d[47:24]; // R8
            hs_q      <= restore_d[23:0]; // R8
         end
         else if (wr_go)
         begin
            case (awaddr_q)
               `DAR_OFF_EE_DATA:
                  if (!I_EE_RD_DONE)
                     ee_data_q <= merge_byte(ee_data_q, wdata_q[7:0],
                                             wstrb_q[0]); // R1
               `DAR_OFF_OBJ_STORE:
                  obj_len_q <= merge_byte(obj_len_q, wdata_q[7:0],
                                          wstrb_q[0]); // R19
               `DAR_OFF_SS_LEN:
                  ss_q <= {merge_byte(ss_q[23:16], wdata_q[23:16],
                                      wstrb_q[2]),
                           merge_byte(ss_q[15:8], wdata_q[15:8],
                                      wstrb_q[1]),
                           merge_byte(ss_q[7:0], wdata_q[7:0],
                                      wstrb_q[0])}; // R9
               `DAR_OFF_HS_LEN:
                  hs_q <= {merge_byte(hs_q[23:16], wdata_q[23:16],
                                      wstrb_q[2]),
                           merge_byte(hs_q[15:8], wdata_q[15:8],
                                      wstrb_q[1]),
                           merge_byte(hs_q[7:0], wdata_q[7:0],
                                      wstrb_q[0])}; // R14
               default:
                  ;
            endcase
         end
         if (wr_go && awaddr_q == `DAR_OFF_CTRL && wstrb_q[0])
         begin
            emu_en_q   <= wdata_q[`DAR_CTRL_EMU_BIT];
            lite_rst_q <= wdata_q[`DAR_CTRL_LITE_BIT];
            prot_en_q  <= wdata_q[`DAR_CTRL_PROT_BIT];
         end
      end
   end

   // ***********************************************************
   // Read decode
   // ***********************************************************
   always @*
   begin
      rd_hit_d = 1'b1;
      rdata_d  = 32'h00000000;
      case (I_ARADDR)
         `DAR_OFF_EE_DATA:   rdata_d = {24'h000000, ee_data_q}; // R1
         `DAR_OFF_OBJ_STORE: rdata_d = {24'h000000, obj_len_q}; // R19
         `DAR_OFF_SS_LEN:    rdata_d = {8'h00, ss_q}; // R9
         `DAR_OFF_HS_LEN:    rdata_d = {8'h00, hs_q}; // R14
         `DAR_OFF_CTRL:      rdata_d = {29'h00000000, prot_en_q,
                                        1'b0, emu_en_q};
         `DAR_OFF_STATUS:    rdata_d = {29'h00000000, img_valid_q,
                                        otp_cfg, ee_present};
         default:            rd_hit_d = 1'b0;
      endcase
   end

   always @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         O_ARREADY <= 1'b0;
         O_RVALID  <= 1'b0;
         O_RDATA   <= 32'h00000000;
         O_RRESP   <= `DAR_RESP_OKAY;
      end
      else
      begin
         O_ARREADY <= ~O_ARREADY & ~O_RVALID & I_ARVALID;
         if (O_ARREADY & I_ARVALID)
         begin
            O_RVALID <= 1'b1;
            O_RDATA  <= rdata_d;
            O_RRESP  <= rd_hit_d ? `DAR_RESP_OKAY : `DAR_RESP_SLVERR;
         end
         else if (O_RVALID & I_RREADY)
            O_RVALID <= 1'b0;
      end
   end

   // ***********************************************************
   // Outputs to descriptor logic and EEPROM controller
   // ***********************************************************
   always @(posedge I_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         O_ATTR_ACTIVE   <= 1'b0;
         O_OBJ_STORE_LEN <= `DAR_ZERO8;
         O_SS_POLL       <= `DAR_ZERO8;
         O_SS_DEV_LEN    <= `DAR_ZERO8;
         O_SS_CFG_LEN    <= `DAR_ZERO8;
         O_HS_POLL       <= `DAR_ZERO8;
         O_HS_DEV_LEN    <= `DAR_ZERO8;
         O_HS_CFG_LEN    <= `DAR_ZERO8;
         O_EE_WR_BYTE    <= `DAR_ZERO8;
         O_EE_WR_VALID   <= 1'b0;
      end
      else
      begin
         O_ATTR_ACTIVE   <= ~ee_present & ~otp_cfg & emu_en_q; // R3
         O_OBJ_STORE_LEN <= obj_len_q;
         O_SS_POLL       <= ss_q[`DAR_POLL_MSB:`DAR_POLL_LSB];
         O_SS_DEV_LEN    <= ss_dev_n; // R11
         O_SS_CFG_LEN    <= ss_cfg_n; // R11
         O_HS_POLL       <= hs_q[`DAR_POLL_MSB:`DAR_POLL_LSB];
         O_HS_DEV_LEN    <= hs_q[`DAR_DEV_MSB:`DAR_DEV_LSB];
         O_HS_CFG_LEN    <= hs_q[`DAR_CFG_MSB:`DAR_CFG_LSB];
         O_EE_WR_BYTE    <= ee_data_q;
         O_EE_WR_VALID   <= I_EE_CMD_ISSUE &&
                            I_EE_CMD == `DAR_CMD_WRITE; // R18
      end
   end

endmodule

/* File: hw/dar_sync.v */
// Purpose: Three-stage synchroniser for a level from outside
// Assumes: One clock, asynchronous active-low reset
// Notes:   Output changes once stages two and three agree
`timescale 1ns/1ps

module dar_sync
(
   input  wire i_clk,
   input  wire i_rst_n,
   input  wire i_d,
   output reg  o_q
);

   reg s1_q;
   reg s2_q;
   reg s3_q;

   // ***********************************************************
   // Stages and agreement filter
   // ***********************************************************
   always @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         o_q  <= 1'b0;
      end
      else
      begin
         s1_q <= i_d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
            o_q <= s3_q;
      end
   end

endmodule
